// ==== rtl/dcg_pkg.sv ====
// shared constants and types of the dual oscillator clock generator
package dcg_pkg;
    localparam int APB_AW = 12;
    localparam logic [APB_AW-1:0] ADDR_STANDBY_CLOCK_CTRL = 12'h000;
    localparam logic [APB_AW-1:0] ADDR_CC = 12'h004;
    localparam logic [APB_AW-1:0] ADDR_PCS = 12'h008;
    localparam logic [7:0] STANDBY_CLOCK_CTRL_RESET = 8'h30;
    localparam logic [7:0] CC_RESET = 8'h00;
    localparam int CC_MAIN_THROUGH_RATE_BIT = 7;
    localparam logic PCS_BIT1 = 1'b1;
    localparam logic PCS_BIT3 = 1'b0;
    localparam int DIV_W_DEF = 6;
    localparam int PERIPH_N_DEF = 4;
    localparam int SYNC_N = 3;

    typedef struct packed {
        logic subFeedbackOff;
        logic cpuSrcSel;
        logic [1:0] cpuDivSel;
        logic spare;
        logic mainOscStop;
        logic stopReq;
        logic haltReq;
    } dcg_standby_clock_ctrl_t;

    typedef enum logic [1:0] {SRC_MAIN, SRC_TO_SUB, SRC_SUB, SRC_TO_MAIN} dcg_src_t;
endpackage : dcg_pkg

// ==== rtl/dcg_sync2.sv ====
// two flip-flop synchroniser for asynchronous pin levels
module dcg_sync2 #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // levels
    input wire logic [W-1:0] asyncIn,
    output logic [W-1:0] syncOut
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= asyncIn;
            sync_q <= meta_q;
        end
    end

    assign syncOut = sync_q;
endmodule : dcg_sync2

// ==== rtl/dcg_divider.sv ====
// free running main clock divider chain, halts with the oscillator
module dcg_divider #(
    parameter int W = 6
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // control and count
    input wire logic run,
    output logic [W-1:0] count
);
    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;

    assign cnt_d = run ? cnt_q + W'(1) : cnt_q;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign count = cnt_q;
endmodule : dcg_divider

// ==== rtl/dcg_clock_gen.sv ====
// clock generator core: registers, source switch, standby and clock ticks
// Functional notes
// - reset loads slowest main speed, 30H/00H
// - main oscillator stopped while reset held
// - five CPU periods on main clock
// - divider bits 4-5 set execution time
// - HALT and STOP available on main
// - bit 7 stops subsystem feedback and clock
// - software may switch CPU to subsystem
// - on subsystem: main may stop, HALT works
// - on subsystem: STOP refused, subsystem runs
// - subsystem feeds timer, watch, clock output; also CPU and watchdog when source
// - subsystem functions run during standby
// - main stop halts main-clocked peripherals
// - main stop bit acts only after switch
// - subsystem execution time ignores divider bits
// - watchdog keeps running on subsystem clock
// - divider derives internal clocks from main
// - selection 000,001,010,011 divide; top bit subsystem
// - mode bit: half or full oscillator rate
// - source switches at synchronised edges, status follows
//
// The APB interface to the registers and the address map were chosen for this implementation.
module dcg_clock_gen
    import dcg_pkg::*;
#(
    parameter int DIV_W = DIV_W_DEF,
    parameter int PERIPH_N = PERIPH_N_DEF
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [APB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // pins
    input wire logic subClkIn,
    input wire logic wakeReq,
    input wire logic extCountIn,
    // oscillator control
    output logic mainOscEn,
    output logic subFeedbackEn,
    // clock ticks
    output logic cpuTick,
    output logic wdtTick,
    output logic [PERIPH_N-1:0] periphTick,
    output logic timerSubTick,
    output logic watchSubTick,
    output logic clkOutSubTick,
    output logic extCountTick,
    // status
    output logic cpuOnSub,
    output logic haltActive,
    output logic stopActive
);
    dcg_standby_clock_ctrl_t standby_clock_ctrl_q;
    dcg_standby_clock_ctrl_t standby_clock_ctrl_d;
    dcg_standby_clock_ctrl_t stbcWr;
    dcg_src_t src_q;
    dcg_src_t src_d;
    logic main_through_rate_q;
    logic main_through_rate_d;
    logic mainRun_q;
    logic mainRun_d;
    logic subPrev_q;
    logic extPrev_q;
    logic [SYNC_N-1:0] pinSync;
    logic [DIV_W-1:0] divCnt;
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;
    logic pready_q;
    logic pslverr_q;
    logic cpuTick_q;
    logic wdtTick_q;
    logic [PERIPH_N-1:0] periphTick_q;
    logic [PERIPH_N-1:0] periphTick_d;
    logic subTick_q;
    logic extTick_q;
    logic mainOscEn_q;
    logic subFeedbackEn_q;
    logic cst_q;
    logic halt_q;
    logic stop_q;

    // tick when the low n bits of the divider are all zero
    function automatic logic lowBitsZero(input logic [DIV_W-1:0] cnt, input logic [2:0] n);
        logic [DIV_W-1:0] mask;
        mask = (DIV_W'(1) << n) - DIV_W'(1);
        return (cnt & mask) == '0;
    endfunction : lowBitsZero

    // pin synchronisers and divider
    dcg_sync2 #(.W(SYNC_N)) u_sync (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .asyncIn({extCountIn, wakeReq, subClkIn}),
        .syncOut(pinSync)
    );

    dcg_divider #(.W(DIV_W)) u_div (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .run(mainRun_q),
        .count(divCnt)
    );

    // decode
    wire logic subSync = pinSync[0];
    wire logic wakeSync = pinSync[1];
    wire logic extSync = pinSync[2];
    wire logic subEdge = subSync & ~subPrev_q & ~standby_clock_ctrl_q.subFeedbackOff;
    wire logic extEdge = extSync & ~extPrev_q;
    wire logic cstNow = (src_q == SRC_SUB) || (src_q == SRC_TO_MAIN);
    wire logic [2:0] mainLog = {1'b0, standby_clock_ctrl_q.cpuDivSel} + {2'b00, ~main_through_rate_q};
    wire logic mainTickNow = mainRun_q & lowBitsZero(divCnt, mainLog);
    wire logic apbSetup = psel & ~penable;
    wire logic apbAccess = psel & penable & pready_q;
    wire logic hitStbc = paddr == ADDR_STANDBY_CLOCK_CTRL;
    wire logic hitCc = paddr == ADDR_CC;
    wire logic hitPcs = paddr == ADDR_PCS;
    wire logic apbHit = hitStbc | hitCc | hitPcs;
    wire logic wrStbc = apbAccess & pwrite & hitStbc;
    wire logic wrCc = apbAccess & pwrite & hitCc;
    wire logic standby = standby_clock_ctrl_q.haltReq | standby_clock_ctrl_q.stopReq;
    wire logic cstNext = (src_d == SRC_SUB) || (src_d == SRC_TO_MAIN);

    // standby control write: STOP refused while subsystem is or becomes source
    always_comb begin
        stbcWr = dcg_standby_clock_ctrl_t'(pwdata[7:0]);
        stbcWr.stopReq = stbcWr.stopReq & ~stbcWr.cpuSrcSel & ~cstNow & ~cstNext;
        standby_clock_ctrl_d = standby_clock_ctrl_q;
        if (wakeSync) begin
            standby_clock_ctrl_d.haltReq = 1'b0;
            standby_clock_ctrl_d.stopReq = 1'b0;
        end
        if (wrStbc) begin
            standby_clock_ctrl_d = stbcWr;
        end
    end

    assign main_through_rate_d = main_through_rate_q | (wrCc & pwdata[CC_MAIN_THROUGH_RATE_BIT]);

    // read data and unmapped answer
    always_comb begin
        prdata_d = '0;
        if (hitStbc) begin
            prdata_d[7:0] = standby_clock_ctrl_q;
        end else if (hitCc) begin
            prdata_d[CC_MAIN_THROUGH_RATE_BIT] = main_through_rate_q;
        end else if (hitPcs) begin
            prdata_d[7:0] = {standby_clock_ctrl_q.subFeedbackOff, standby_clock_ctrl_q.cpuSrcSel, standby_clock_ctrl_q.cpuDivSel,
                             PCS_BIT3, standby_clock_ctrl_q.mainOscStop, PCS_BIT1, cstNow};
        end
    end

    // source switch only on a sub edge that meets a whole main period
    always_comb begin
        src_d = src_q;
        case (src_q)
            SRC_MAIN: begin
                if (standby_clock_ctrl_q.cpuSrcSel) begin
                    src_d = SRC_TO_SUB;
                end
            end
            SRC_TO_SUB: begin
                if (!standby_clock_ctrl_q.cpuSrcSel) begin
                    src_d = SRC_MAIN;
                end else if (subEdge && mainTickNow) begin
                    src_d = SRC_SUB;
                end
            end
            SRC_SUB: begin
                if (!standby_clock_ctrl_q.cpuSrcSel) begin
                    src_d = SRC_TO_MAIN;
                end
            end
            SRC_TO_MAIN: begin
                if (standby_clock_ctrl_q.cpuSrcSel) begin
                    src_d = SRC_SUB;
                end else if (subEdge && mainTickNow) begin
                    src_d = SRC_MAIN;
                end
            end
            default: begin
                src_d = SRC_MAIN;
            end
        endcase
    end

    // main oscillator: stops on STOP, or on stop bit once running from subsystem
    always_comb begin
        mainRun_d = mainRun_q;
        if (standby_clock_ctrl_q.stopReq) begin
            mainRun_d = 1'b0;
        end else if (standby_clock_ctrl_q.mainOscStop && cstNow) begin
            mainRun_d = 1'b0;
        end else if (!standby_clock_ctrl_q.mainOscStop) begin
            mainRun_d = 1'b1;
        end
    end

    // peripheral taps of the main divider
    always_comb begin
        periphTick_d = '0;
        for (int k = 0; k < PERIPH_N; k++) begin
            periphTick_d[k] = mainRun_q & ~standby_clock_ctrl_q.stopReq
                              & lowBitsZero(divCnt, 3'(k + 1) + {2'b00, ~main_through_rate_q});
        end
    end

    // state registers
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            standby_clock_ctrl_q <= dcg_standby_clock_ctrl_t'(STANDBY_CLOCK_CTRL_RESET);
            main_through_rate_q <= CC_RESET[CC_MAIN_THROUGH_RATE_BIT];
            src_q <= SRC_MAIN;
            mainRun_q <= 1'b0;
            subPrev_q <= 1'b0;
            extPrev_q <= 1'b0;
        end else begin
            standby_clock_ctrl_q <= standby_clock_ctrl_d;
            main_through_rate_q <= main_through_rate_d;
            src_q <= src_d;
            mainRun_q <= mainRun_d;
            subPrev_q <= subSync;
            extPrev_q <= extSync;
        end
    end

    // apb answer registers
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            prdata_q <= '0;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            prdata_q <= apbSetup ? prdata_d : '0;
            pready_q <= apbSetup;
            pslverr_q <= apbSetup & ~apbHit;
        end
    end

    // output tick and status registers
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            cpuTick_q <= 1'b0;
            wdtTick_q <= 1'b0;
            periphTick_q <= '0;
            subTick_q <= 1'b0;
            extTick_q <= 1'b0;
            mainOscEn_q <= 1'b0;
            subFeedbackEn_q <= 1'b0;
            cst_q <= 1'b0;
            halt_q <= 1'b0;
            stop_q <= 1'b0;
        end else begin
            cpuTick_q <= ~standby & (cstNow ? subEdge : mainTickNow);
            wdtTick_q <= ~standby_clock_ctrl_q.stopReq & (cstNow ? subEdge : mainTickNow);
            periphTick_q <= periphTick_d;
            subTick_q <= subEdge;
            extTick_q <= extEdge;
            mainOscEn_q <= mainRun_q;
            subFeedbackEn_q <= ~standby_clock_ctrl_q.subFeedbackOff;
            cst_q <= cstNow;
            halt_q <= standby_clock_ctrl_q.haltReq;
            stop_q <= standby_clock_ctrl_q.stopReq;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign cpuTick = cpuTick_q;
    assign wdtTick = wdtTick_q;
    assign periphTick = periphTick_q;
    assign timerSubTick = subTick_q;
    assign watchSubTick = subTick_q;
    assign clkOutSubTick = subTick_q;
    assign extCountTick = extTick_q;
    assign mainOscEn = mainOscEn_q;
    assign subFeedbackEn = subFeedbackEn_q;
    assign cpuOnSub = cst_q;
    assign haltActive = halt_q;
    assign stopActive = stop_q;

    // checks
    a_reset_load: assert property (@(posedge sys_clk) $rose(resetn) |->
        standby_clock_ctrl_q == dcg_standby_clock_ctrl_t'(STANDBY_CLOCK_CTRL_RESET) && !main_through_rate_q) else $error("reset values wrong");
    a_osc_reset: assert property (@(posedge sys_clk) $rose(resetn) |-> !mainRun_q)
        else $error("main oscillator ran in reset");
    a_mck_holds: assert property (@(posedge sys_clk) disable iff (!resetn)
        mainRun_q && standby_clock_ctrl_q.mainOscStop && !cstNow && !standby_clock_ctrl_q.stopReq |=> mainRun_q)
        else $error("main stopped while still source");
    a_mck_stops: assert property (@(posedge sys_clk) disable iff (!resetn)
        standby_clock_ctrl_q.mainOscStop && cstNow |=> !mainRun_q ##1 !mainOscEn_q)
        else $error("main not stopped on subsystem");
    a_stop_refused: assert property (@(posedge sys_clk) disable iff (!resetn)
        cstNow |-> !standby_clock_ctrl_q.stopReq) else $error("stop on subsystem");
    a_sub_fixed: assert property (@(posedge sys_clk) disable iff (!resetn)
        (src_q == SRC_SUB) && !standby |=> cpuTick_q == $past(subEdge))
        else $error("subsystem tick not fixed");
    a_switch_sync: assert property (@(posedge sys_clk) disable iff (!resetn)
        $changed(cstNow) |-> $past(subEdge) && $past(mainTickNow)) else $error("unsynchronised switch");
    a_full_rate: assert property (@(posedge sys_clk) disable iff (!resetn)
        !cstNow && mainRun_q && !standby && main_through_rate_q && standby_clock_ctrl_q.cpuDivSel == 2'b00 |=> cpuTick_q)
        else $error("full rate tick missing");
    a_halt_gates: assert property (@(posedge sys_clk) disable iff (!resetn)
        standby_clock_ctrl_q.haltReq |=> !cpuTick_q) else $error("cpu ticked in halt");
    a_feedback_off: assert property (@(posedge sys_clk) disable iff (!resetn)
        standby_clock_ctrl_q.subFeedbackOff |=> !subFeedbackEn_q && !subTick_q) else $error("subsystem not stopped");
    a_periph_stop: assert property (@(posedge sys_clk) disable iff (!resetn)
        !mainRun_q |=> periphTick_q == '0) else $error("peripheral tick without main");
    a_main_through_rate_sticky: assert property (@(posedge sys_clk) disable iff (!resetn)
        main_through_rate_q |=> main_through_rate_q) else $error("mode bit cleared");
    a_stop_gates: assert property (@(posedge sys_clk) disable iff (!resetn)
        standby_clock_ctrl_q.stopReq |=> !cpuTick_q && !wdtTick_q && periphTick_q == '0)
        else $error("tick during stop");
    a_wake_clears: assert property (@(posedge sys_clk) disable iff (!resetn)
        wakeSync && !wrStbc |=> !standby_clock_ctrl_q.haltReq && !standby_clock_ctrl_q.stopReq)
        else $error("standby not released");
    a_sub_standby: assert property (@(posedge sys_clk) disable iff (!resetn)
        standby && subEdge |=> subTick_q)
        else $error("subsystem tick lost in standby");
    a_osc_release: assert property (@(posedge sys_clk) disable iff (!resetn)
        $rose(resetn) |=> mainRun_q) else $error("main oscillator not resumed");
    a_osc_restart: assert property (@(posedge sys_clk) disable iff (!resetn)
        !standby_clock_ctrl_q.mainOscStop && !standby_clock_ctrl_q.stopReq |=> mainRun_q)
        else $error("main oscillator not restarted");

    // main scenarios
    c_to_sub: cover property (@(posedge sys_clk) disable iff (!resetn) $rose(cst_q));
    c_to_main: cover property (@(posedge sys_clk) disable iff (!resetn) $fell(cst_q));
    c_halt: cover property (@(posedge sys_clk) disable iff (!resetn) $rose(halt_q));
    c_stop: cover property (@(posedge sys_clk) disable iff (!resetn) $rose(stop_q));
    c_main_off: cover property (@(posedge sys_clk) disable iff (!resetn) $fell(mainOscEn_q));
endmodule : dcg_clock_gen

// ==== tb/tb_dual_oscillator_clock_generator.sv ====
// self-checking bench of the dual oscillator clock generator
module tb_dual_oscillator_clock_generator
    import dcg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic [7:0] standby_clock_ctrl; logic [7:0] cc; int per;} dcg_row_t;
    logic sys_clk = 1'h0, resetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [APB_AW-1:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic subClkIn = 1'h0, wakeReq = 1'h0, extCountIn = 1'h0, err;
    logic pready, pslverr, mainOscEn, subFeedbackEn, cpuTick, wdtTick, timerSubTick, watchSubTick;
    logic clkOutSubTick, extCountTick, cpuOnSub, haltActive, stopActive;
    logic [PERIPH_N_DEF-1:0] periphTick;
    int errors = 0, total_checks = 0, cyc = 0, cCpu, cWdt, cPer, cSub, cExt, cPerAll;
    dcg_row_t rows [7] = '{'{8'h00, 8'h00, 2}, '{8'h10, 8'h00, 4}, '{8'h20, 8'h00, 8}, '{8'h30, 8'h00, 16},
        '{8'h30, 8'h80, 8}, '{8'h00, 8'h80, 1}, '{8'h10, 8'h80, 2}};

    dcg_clock_gen #(.DIV_W(DIV_W_DEF), .PERIPH_N(PERIPH_N_DEF)) u_dut (
        .sys_clk(sys_clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .subClkIn(subClkIn), .wakeReq(wakeReq), .extCountIn(extCountIn), .mainOscEn(mainOscEn),
        .subFeedbackEn(subFeedbackEn), .cpuTick(cpuTick), .wdtTick(wdtTick), .periphTick(periphTick),
        .timerSubTick(timerSubTick), .watchSubTick(watchSubTick), .clkOutSubTick(clkOutSubTick),
        .extCountTick(extCountTick), .cpuOnSub(cpuOnSub), .haltActive(haltActive), .stopActive(stopActive)
    );

    always #20 sys_clk = ~sys_clk;

    // sub clock stops without feedback resistor, external count free running
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        subClkIn <= subFeedbackEn & cyc[4];
        extCountIn <= cyc[3];
        if (cyc == 20000) begin
            errors++;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %s expected %0h seen %0h", nm, exp, got);
        end
    endtask : chk

    task automatic chk_cnt(input string nm, input int exp, input int got);
        total_checks++;
        if (got != exp) begin
            errors++;
            $display("ERROR %s expected %0d seen %0d", nm, exp, got);
        end
    endtask : chk_cnt

    task automatic apb_xfer(input logic wr, input logic [APB_AW-1:0] a, input logic [7:0] d);
        int n;
        @(posedge sys_clk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge sys_clk);
        penable <= 1'h1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'h1);
        chk_cnt("pready latency", 1, n);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb_xfer

    task automatic wr(input logic [APB_AW-1:0] a, input logic [7:0] d);
        apb_xfer(1'h1, a, d);
    endtask : wr

    task automatic rchk(input string nm, input logic [APB_AW-1:0] a, input logic [31:0] exp);
        apb_xfer(1'h0, a, 8'h00);
        chk(nm, exp, rd);
    endtask : rchk

    // counts tick pulses over n cycles
    task automatic run(input int n);
        cCpu = 0; cWdt = 0; cPer = 0; cSub = 0; cExt = 0;
        cPerAll = 0;
        repeat (n) begin
            @(posedge sys_clk);
            cCpu += int'(cpuTick === 1'h1);
            cWdt += int'(wdtTick === 1'h1);
            cPer += int'(periphTick[0] === 1'h1);
            cPerAll += $countones(periphTick);
            cSub += int'((timerSubTick & watchSubTick & clkOutSubTick) === 1'h1);
            cExt += int'(extCountTick === 1'h1);
        end
    endtask : run

    task automatic do_reset();
        resetn <= 1'h0;
        repeat (4) @(posedge sys_clk);
        chk("mainOscEn in reset", 32'h0, {31'h0, mainOscEn});
        resetn <= 1'h1;
        run(4);
        chk("mainOscEn after reset", 32'h1, {31'h0, mainOscEn});
    endtask : do_reset

    task automatic wait_src(input logic v);
        int n;
        n = 0;
        while (cpuOnSub !== v && n < 100) begin
            @(posedge sys_clk);
            n++;
        end
        chk("cpuOnSub", {31'h0, v}, {31'h0, cpuOnSub});
    endtask : wait_src

    task automatic wake();
        wakeReq <= 1'h1;
        run(4);
        wakeReq <= 1'h0;
        run(2);
    endtask : wake

    initial begin
        do_reset();
        rchk("standby reset", ADDR_STANDBY_CLOCK_CTRL, 32'h30);
        rchk("mode reset", ADDR_CC, 32'h00);
        rchk("status reset", ADDR_PCS, 32'h32);
        foreach (rows[i]) begin
            wr(ADDR_STANDBY_CLOCK_CTRL, rows[i].standby_clock_ctrl);
            wr(ADDR_CC, rows[i].cc);
            run(32);
            run(64);
            chk_cnt("cpuTick rate", 64 / rows[i].per, cCpu);
            chk_cnt("periphTick rate", rows[i].cc[7] ? 32 : 16, cPer);
            chk_cnt("periphTick all taps", rows[i].cc[7] ? 60 : 30, cPerAll);
        end
        wr(ADDR_CC, 8'h00);
        rchk("mode sticky", ADDR_CC, 32'h80);
        apb_xfer(1'h0, 12'h00C, 8'h00);
        chk("unmapped err", 32'h1, {31'h0, err});
        chk("unmapped data", 32'h0, rd);
        wr(ADDR_STANDBY_CLOCK_CTRL, 8'h04);
        run(8);
        chk("mainOscEn stop on main", 32'h1, {31'h0, mainOscEn});
        wr(ADDR_STANDBY_CLOCK_CTRL, 8'h44);
        wait_src(1'h1);
        run(4);
        chk("mainOscEn on sub", 32'h0, {31'h0, mainOscEn});
        rchk("status on sub", ADDR_PCS, 32'h47);
        run(128);
        chk_cnt("cpu on sub", 4, cCpu);
        chk_cnt("wdt on sub", 4, cWdt);
        chk_cnt("periph main off", 0, cPer);
        chk_cnt("sub ticks", 4, cSub);
        wr(ADDR_STANDBY_CLOCK_CTRL, 8'h74);
        run(128);
        chk_cnt("cpu div ignored", 4, cCpu);
        wr(ADDR_STANDBY_CLOCK_CTRL, 8'h46);
        rchk("stop refused", ADDR_STANDBY_CLOCK_CTRL, 32'h44);
        chk("stopActive on sub", 32'h0, {31'h0, stopActive});
        wr(ADDR_STANDBY_CLOCK_CTRL, 8'h45);
        run(128);
        chk("halt on sub", 32'h1, {31'h0, haltActive});
        chk_cnt("sub ticks in halt", 4, cSub);
        chk_cnt("wdt in halt", 4, cWdt);
        wake();
        chk("halt released", 32'h0, {31'h0, haltActive});
        wr(ADDR_STANDBY_CLOCK_CTRL, 8'h40);
        run(4);
        chk("main restarted", 32'h1, {31'h0, mainOscEn});
        wr(ADDR_STANDBY_CLOCK_CTRL, 8'h00);
        wait_src(1'h0);
        wr(ADDR_STANDBY_CLOCK_CTRL, 8'h02);
        run(4);
        run(128);
        chk("stop on main", 32'h1, {31'h0, stopActive});
        chk_cnt("periph in stop", 0, cPer);
        chk_cnt("all taps in stop", 0, cPerAll);
        chk_cnt("ext count in stop", 8, cExt);
        chk_cnt("sub ticks in stop", 4, cSub);
        wake();
        chk("stop released", 32'h0, {31'h0, stopActive});
        wr(ADDR_STANDBY_CLOCK_CTRL, 8'h01);
        run(8);
        chk("halt on main", 32'h1, {31'h0, haltActive});
        wake();
        wr(ADDR_STANDBY_CLOCK_CTRL, 8'h80);
        run(64);
        chk("feedback off", 32'h0, {31'h0, subFeedbackEn});
        run(128);
        chk_cnt("sub stopped", 0, cSub);
        rchk("standby readback", ADDR_STANDBY_CLOCK_CTRL, 32'h80);
        do_reset();
        rchk("standby second reset", ADDR_STANDBY_CLOCK_CTRL, 32'h30);
        rchk("mode second reset", ADDR_CC, 32'h00);
        stop_test();
    end
endmodule : tb_dual_oscillator_clock_generator
